// file: psr_pkg.sv
package psr_pkg;

	localparam int unsigned ADDR_W   = 13;
	localparam int unsigned HDR_BITS = 16;
	localparam int unsigned FRM_BITS = 24;
	localparam int unsigned CNT_W    = 5;

	localparam logic [ADDR_W-1:0] LOOP1_STATE_AND_REFERENCE = 13'h0082;
	localparam logic [ADDR_W-1:0] HOLDOVER_AVERAGED_CODE    = 13'h0083;
	localparam logic [ADDR_W-1:0] HOLDOVER_CURRENT_CODE     = 13'h0084;
	localparam logic [ADDR_W-1:0] LOOP1_REFERENCE_FLAGS     = 13'h0085;
	localparam logic [ADDR_W-1:0] HOLDOVER_EXIT_PHASE       = 13'h0086;
	localparam logic [ADDR_W-1:0] LOOP1_RESERVED_STATUS     = 13'h0087;
	localparam logic [ADDR_W-1:0] AUTOTUNE_CAPACITOR_BANK   = 13'h008c;
	localparam logic [ADDR_W-1:0] TUNE_ERROR_LOW            = 13'h008d;
	localparam logic [ADDR_W-1:0] TUNE_ERROR_HIGH_AND_FLAGS = 13'h008e;
	localparam logic [ADDR_W-1:0] LOOP2_STATE_MACHINES      = 13'h008f;
	localparam logic [ADDR_W-1:0] LOOP2_RESERVED_STATUS     = 13'h0090;

	localparam int unsigned RD_BIT    = 15;
	localparam int unsigned FLAG_LOS  = 3;
	localparam int unsigned FLAG_FAST = 2;
	localparam int unsigned FLAG_ADC  = 1;
	localparam int unsigned FLAG_RNG  = 0;

	localparam logic [2:0] L1_RESET   = 3'h0;
	localparam logic [2:0] L1_ACQUIRE = 3'h1;
	localparam logic [2:0] L1_LOCKED  = 3'h2;
	localparam logic [2:0] L1_INVALID = 3'h3;
	localparam logic [2:0] L1_HOLD    = 3'h4;
	localparam logic [2:0] L1_EXIT    = 3'h5;

	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [13:0] ERR_RST  = 14'h0000;
	localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

endpackage

// file: psr_top.sv
`timescale 1ns/1ps
`default_nettype none
module psr_top
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_sclk_i,
	input  wire logic        spi_sdi_i,
	output logic             spi_sdo_o,
	output logic             spi_sdo_oe_o,
	input  wire logic [2:0]  loop1_state_code_i,
	input  wire logic [1:0]  preferred_reference_index_i,
	input  wire logic [1:0]  active_reference_index_i,
	input  wire logic [6:0]  holdover_avg_code_i,
	input  wire logic [6:0]  holdover_cur_code_i,
	input  wire logic        holdover_comparator_i,
	input  wire logic        active_ref_los_i,
	input  wire logic        ref_faster_i,
	input  wire logic        adc_moving_i,
	input  wire logic        adc_out_of_range_i,
	input  wire logic [1:0]  exit_phase_i,
	input  wire logic        autotune_done_i,
	input  wire logic [7:0]  autotune_bank_i,
	input  wire logic [13:0] tune_error_i,
	input  wire logic        tune_error_negative_i,
	input  wire logic        autotune_busy_i,
	input  wire logic [3:0]  autotune_state_code_i,
	input  wire logic [3:0]  sync_carry_state_code_i
);
	import psr_pkg::*;

	logic [2:0]  l1_state_q;
	logic [2:0]  l1_state_d;
	logic [1:0]  pref_q;
	logic [1:0]  pref_d;
	logic [1:0]  act_q;
	logic [1:0]  act_d;
	logic [6:0]  avg_q;
	logic [6:0]  avg_d;
	logic [6:0]  cur_q;
	logic [6:0]  cur_d;
	logic        cmp_q;
	logic        cmp_d;
	logic [3:0]  flags_q;
	logic [3:0]  flags_d;
	logic [1:0]  phase_q;
	logic [1:0]  phase_d;
	logic [7:0]  bank_q;
	logic [7:0]  bank_d;
	logic [13:0] err_q;
	logic [13:0] err_d;
	logic        neg_q;
	logic        neg_d;
	logic        busy_q;
	logic        busy_d;
	logic [3:0]  at_q;
	logic [3:0]  at_d;
	logic [3:0]  sc_q;
	logic [3:0]  sc_d;

	logic             sclk_q;
	logic             sclk_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [15:0]      hdr_q;
	logic [15:0]      hdr_d;
	logic             rd_q;
	logic             rd_d;
	logic [7:0]       out_q;
	logic [7:0]       out_d;
	logic             sdo_q;
	logic             sdo_d;
	logic             oe_q;
	logic             oe_d;
	logic             rise;
	logic             fall;
	logic [15:0]      hdr_full;

	function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
		logic [7:0] r;
		r = BYTE_RST;
		unique case (a)
			LOOP1_STATE_AND_REFERENCE:
				r = {1'b0, pref_q, act_q, l1_state_q};
			HOLDOVER_AVERAGED_CODE:
				r = {1'b0, avg_q};
			HOLDOVER_CURRENT_CODE:
				r = {cmp_q, cur_q};
			LOOP1_REFERENCE_FLAGS:
				r = {4'h0, flags_q};
			HOLDOVER_EXIT_PHASE:
				r = {3'h0, phase_q, 3'h0};
			AUTOTUNE_CAPACITOR_BANK:
				r = bank_q;
			TUNE_ERROR_LOW:
				r = err_q[7:0];
			TUNE_ERROR_HIGH_AND_FLAGS:
				r = {busy_q, neg_q, err_q[13:8]};
			LOOP2_STATE_MACHINES:
				r = {at_q, sc_q};
			default:
				r = BYTE_RST;
		endcase
		return r;
	endfunction

	// Loop-one state and reference selection
	always_comb
	begin
		l1_state_d = loop1_state_code_i;
		pref_d     = preferred_reference_index_i;
		act_d      = active_reference_index_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			l1_state_q <= L1_RESET;
			pref_q     <= 2'h0;
			act_q      <= 2'h0;
		end
		else
		begin
			l1_state_q <= l1_state_d;
			pref_q     <= pref_d;
			act_q      <= act_d;
		end
	end

	// Holdover codes, comparator and exit phase
	always_comb
	begin
		avg_d   = holdover_avg_code_i;
		cur_d   = holdover_cur_code_i;
		cmp_d   = holdover_comparator_i;
		phase_d = exit_phase_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			avg_q   <= 7'h00;
			cur_q   <= 7'h00;
			cmp_q   <= 1'b0;
			phase_q <= 2'h0;
		end
		else
		begin
			avg_q   <= avg_d;
			cur_q   <= cur_d;
			cmp_q   <= cmp_d;
			phase_q <= phase_d;
		end
	end

	// Reference and converter flags
	always_comb
	begin
		flags_d[FLAG_LOS]  = active_ref_los_i;
		flags_d[FLAG_FAST] = ref_faster_i;
		flags_d[FLAG_ADC]  = adc_moving_i;
		flags_d[FLAG_RNG]  = adc_out_of_range_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			flags_q <= 4'h0;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	// Capacitor bank, held until autotune completes again
	always_comb
	begin
		bank_d = autotune_done_i ? autotune_bank_i : bank_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			bank_q <= BYTE_RST;
		end
		else
		begin
			bank_q <= bank_d;
		end
	end

	// Loop-two tuning error and state codes
	always_comb
	begin
		err_d  = tune_error_i;
		neg_d  = tune_error_negative_i;
		busy_d = autotune_busy_i;
		at_d   = autotune_state_code_i;
		sc_d   = sync_carry_state_code_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			err_q  <= ERR_RST;
			neg_q  <= 1'b0;
			busy_q <= 1'b0;
			at_q   <= 4'h0;
			sc_q   <= 4'h0;
		end
		else
		begin
			err_q  <= err_d;
			neg_q  <= neg_d;
			busy_q <= busy_d;
			at_q   <= at_d;
			sc_q   <= sc_d;
		end
	end

	// Serial port: header of read flag, two ignored bits, 13-bit address
	assign rise     = spi_sclk_i & ~sclk_q;
	assign fall     = ~spi_sclk_i & sclk_q;
	assign hdr_full = {hdr_q[14:0], spi_sdi_i};

	always_comb
	begin
		sclk_d = spi_sclk_i;
		cnt_d  = cnt_q;
		hdr_d  = hdr_q;
		rd_d   = rd_q;
		out_d  = out_q;
		sdo_d  = sdo_q;
		oe_d   = oe_q;
		if (spi_cs_n_i)
		begin
			cnt_d = CNT_RST;
			rd_d  = 1'b0;
			sdo_d = 1'b0;
			oe_d  = 1'b0;
		end
		else if (rise)
		begin
			if (cnt_q < CNT_W'(HDR_BITS))
			begin
				hdr_d = hdr_full;
				cnt_d = cnt_q + 5'h01;
				if (cnt_q == CNT_W'(HDR_BITS - 1))
				begin
					rd_d  = hdr_full[RD_BIT];
					out_d = read_reg(hdr_full[ADDR_W-1:0]);
				end
			end
			else if (cnt_q < CNT_W'(FRM_BITS))
			begin
				cnt_d = cnt_q + 5'h01;
			end
		end
		else if (fall)
		begin
			if (rd_q && cnt_q >= CNT_W'(HDR_BITS) &&
				cnt_q < CNT_W'(FRM_BITS))
			begin
				sdo_d = out_q[7];
				out_d = {out_q[6:0], 1'b0};
				oe_d  = 1'b1;
			end
			else
			begin
				sdo_d = 1'b0;
				oe_d  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			sclk_q <= 1'b0;
			cnt_q  <= CNT_RST;
			hdr_q  <= 16'h0000;
			rd_q   <= 1'b0;
			out_q  <= BYTE_RST;
			sdo_q  <= 1'b0;
			oe_q   <= 1'b0;
		end
		else
		begin
			sclk_q <= sclk_d;
			cnt_q  <= cnt_d;
			hdr_q  <= hdr_d;
			rd_q   <= rd_d;
			out_q  <= out_d;
			sdo_q  <= sdo_d;
			oe_q   <= oe_d;
		end
	end

	assign spi_sdo_o    = sdo_q;
	assign spi_sdo_oe_o = oe_q;

endmodule
`default_nettype wire

// file: psr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module psr_asserts
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_idle;
		spi_cs_n_i [*3];
	endsequence
	sequence s_fell;
		$past(!spi_sclk_i) || $past(spi_cs_n_i) || $past(spi_cs_n_i, 2);
	endsequence
	property p_rst;
		disable iff (1'b0) !reset_n_i |=> !spi_sdo_o && !spi_sdo_oe_o;
	endproperty
	property p_chg;
		$changed(spi_sdo_o) |-> s_fell;
	endproperty
	property p_on;
		$rose(spi_sdo_oe_o) |-> $past(!spi_sclk_i) && $past(!spi_cs_n_i, 2);
	endproperty
	property p_off;
		$fell(spi_sdo_oe_o) |-> s_fell;
	endproperty
	property p_idle;
		s_idle |-> !spi_sdo_oe_o;
	endproperty
	property p_hold;
		spi_sclk_i && !spi_cs_n_i && spi_sdo_oe_o
			|=> $stable(spi_sdo_o) && spi_sdo_oe_o;
	endproperty
	property p_boot;
		$rose(reset_n_i) |-> !spi_sdo_oe_o ##1 !spi_sdo_oe_o;
	endproperty
	property p_end;
		$fell(spi_sdo_oe_o) && !spi_cs_n_i |-> !spi_sdo_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	a_chg: assert property (p_chg) else $error("sdo");
	a_on: assert property (p_on) else $error("oe on");
	a_off: assert property (p_off) else $error("oe off");
	a_idle: assert property (p_idle) else $error("idle");
	a_hold: assert property (p_hold) else $error("hold");
	a_boot: assert property (p_boot) else $error("boot");
	a_end: assert property (p_end) else $error("end");
endmodule
bind psr_top psr_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i),
	.spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o));
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected %0t got %h want %h", $time, a, b); end end
module tb_top;
	import psr_pkg::*;
	logic        clk_i, reset_n_i, cs_n, sclk, sdi, done;
	logic [59:0] s;
	logic [7:0]  bk, q;
	logic [23:0] fr;
	wire         sdo, oe;
	int          n_fail, n_compared, k, j;
	logic [12:0] ad [12] = '{13'h82, 13'h83, 13'h84, 13'h85, 13'h86,
		13'h87, 13'h8c, 13'h8d, 13'h8e, 13'h8f, 13'h90, 13'h100};
	logic [3:0]  sy [6] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'he, 4'hc};
	psr_top u_dut
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n),
		.spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
		.spi_sdo_oe_o(oe), .loop1_state_code_i(s[59:57]),
		.preferred_reference_index_i(s[56:55]),
		.active_reference_index_i(s[54:53]),
		.holdover_avg_code_i(s[52:46]), .holdover_cur_code_i(s[45:39]),
		.holdover_comparator_i(s[38]), .active_ref_los_i(s[37]),
		.ref_faster_i(s[36]), .adc_moving_i(s[35]),
		.adc_out_of_range_i(s[34]), .exit_phase_i(s[33:32]),
		.autotune_done_i(done), .autotune_bank_i(s[31:24]),
		.tune_error_i(s[23:10]), .tune_error_negative_i(s[9]),
		.autotune_busy_i(s[8]), .autotune_state_code_i(s[7:4]),
		.sync_carry_state_code_i(s[3:0])
	);
	initial
	begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	function automatic logic [7:0] ex(input logic [12:0] a);
		case (a)
		13'h82: ex = {1'b0, s[56:53], s[59:57]};
		13'h83: ex = {1'b0, s[52:46]};
		13'h84: ex = {s[38], s[45:39]};
		13'h85: ex = {4'h0, s[37:34]};
		13'h86: ex = {3'h0, s[33:32], 3'h0};
		13'h8c: ex = bk;
		13'h8d: ex = s[17:10];
		13'h8e: ex = {s[8], s[9], s[23:18]};
		13'h8f: ex = s[7:0];
		default: ex = 8'h00;
		endcase
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic xfer(input logic [23:0] f, output logic [7:0] r);
		r = 8'h00;
		cs_n = 0;
		for (int i = 23; i >= 0; i--)
		begin
			sdi = f[i];
			step(4);
			sclk = 1;
			if (i < 8)
			begin
				r[i] = sdo;
				`CHK(oe, f[23])
			end
			step(4);
			sclk = 0;
		end
		step(4);
		`CHK(oe, 1'b0)
		cs_n = 1;
		step(2);
	endtask
	task automatic end_sim;
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		{reset_n_i, sclk, sdi, done} = 4'h0;
		cs_n = 1;
		s = '0;
		bk = '0;
		step(3);
		reset_n_i = 1;
		for (k = 0; k < 12; k++)
		begin
			s = 60'(60'h5a3c96e1b4d2f87 * (k + 1));
			s[59:57] = 3'(k % 6);
			s[7:4] = 4'(k);
			s[3:0] = sy[k % 6];
			done = k[0];
			if (k[0])
				bk = s[31:24];
			step(1);
			done = 0;
			step(1);
			for (j = 0; j < 12; j++)
			begin
				xfer({3'h4, ad[j], 8'h00}, q);
				`CHK(q, ex(ad[j]))
			end
		end
		xfer({3'h0, 13'h8c, 8'hff}, q);
		xfer({3'h4, 13'h8c, 8'h00}, q);
		`CHK(q, bk)
		fr = {3'h4, 13'h8c, 8'h00};
		cs_n = 0;
		for (k = 23; k >= 7; k--)
		begin
			sdi = fr[k];
			step(4);
			sclk = 1;
			step(4);
			sclk = 0;
		end
		step(4);
		`CHK(oe, 1'b1)
		reset_n_i = 0;
		step(2);
		`CHK({sdo, oe}, 2'b00)
		cs_n = 1;
		reset_n_i = 1;
		step(1);
		xfer({3'h4, 13'h8c, 8'h00}, q);
		`CHK(q, 8'h00)
		end_sim;
	end
endmodule
`default_nettype wire
